// >>> pkg/dur_pkg.sv
//----------------------------------------------------------------------
// Purpose: Shared constants and types of the dual serial register set
// Assumes: One clock, registers reached over the parallel host port
// Notes:   Offsets are 4-bit port addresses
//----------------------------------------------------------------------
package dur_pkg;

   //------------------------------------------------------------
   // Port addresses
   //------------------------------------------------------------
   localparam logic [3:0] ADR_MODE_A  = 4'h0; // mode_one / mode_two of A
   localparam logic [3:0] ADR_STAT_A  = 4'h1; // status read, clock select write
   localparam logic [3:0] ADR_CMD_A   = 4'h2;
   localparam logic [3:0] ADR_AUX     = 4'h4; // input change read, aux write
   localparam logic [3:0] ADR_INT     = 4'h5; // int status read, mask write
   localparam logic [3:0] ADR_CT_HI   = 4'h6;
   localparam logic [3:0] ADR_CT_LO   = 4'h7;
   localparam logic [3:0] ADR_MODE_B  = 4'h8;
   localparam logic [3:0] ADR_STAT_B  = 4'h9;
   localparam logic [3:0] ADR_CMD_B   = 4'hA;
   localparam logic [3:0] ADR_VECTOR  = 4'hC;
   localparam logic [3:0] ADR_ROUTE   = 4'hD;
   localparam logic [3:0] ADR_OP_SET  = 4'hE;
   localparam logic [3:0] ADR_OP_CLR  = 4'hF;

   //------------------------------------------------------------
   // Reset values and command codes
   //------------------------------------------------------------
   localparam logic [7:0] RST_ZERO    = 8'h00;
   localparam logic [7:0] RST_VECTOR  = 8'h0F;
   localparam logic [1:0] CMD_ENABLE  = 2'h1;
   localparam logic [1:0] CMD_DISABLE = 2'h2;
   localparam logic [2:0] BASE_BITS   = 3'h5;

   //------------------------------------------------------------
   // Field types
   //------------------------------------------------------------
   typedef enum logic [1:0] {PAR_WITH = 2'h0, PAR_FORCE = 2'h1, PAR_NONE = 2'h2,
                             PAR_MULTI = 2'h3} dur_par_t;
   typedef enum logic [1:0] {CM_NORMAL = 2'h0, CM_ECHO = 2'h1, CM_LOCAL = 2'h2,
                             CM_REMOTE = 2'h3} dur_cmode_t;

   // Decoded channel setup towards the serial datapath
   typedef struct packed {
      logic       rx_rts_ctl;
      logic       rx_int_full;
      logic       block_err;
      dur_par_t   parity_mode;
      logic       parity_odd;
      logic [3:0] data_bits;
      dur_cmode_t chan_mode;
      logic       tx_rts_ctl;
      logic       cts_gate;
      logic [3:0] stop_len;
      logic [3:0] rx_clk_sel;
      logic [3:0] tx_clk_sel;
      logic       tx_enable;
      logic       rx_enable;
      logic       tx_addr_flag;
   } dur_cfg_t;

   // Live conditions from the serial datapath
   typedef struct packed {
      logic rx_break;
      logic framing_err;
      logic parity_err;
      logic overrun_err;
      logic transmitter_empty;
      logic transmit_ready;
      logic fifo_full_flag;
      logic receive_ready;
      logic rx_addr_flag;
      logic break_change;
   } dur_stat_t;

endpackage : dur_pkg

// >>> core/dur_chan.sv
//----------------------------------------------------------------------
// Purpose: One channel's mode, clock select, command and status set
// Assumes: Strobes are qualified by chip select; clock enable gates the state register
// Notes:   Mode address steps from mode_one to mode_two after access
//----------------------------------------------------------------------
`timescale 1ns/1ps
module dur_chan
   import dur_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       clk_en,
   // Register strobes
   input  wire logic       mode_acc,
   input  wire logic       mode_wr,
   input  wire logic       csr_wr,
   input  wire logic       cmd_wr,
   input  wire logic [7:0] wdata,
   // Datapath side
   input  wire dur_stat_t  stat_in,
   output dur_cfg_t        cfg,
   output logic [7:0]      status,
   output logic [7:0]      mode_rdata
);

   typedef enum logic {PTR_ONE, PTR_TWO} dur_ptr_t;

   typedef struct packed {
      logic [7:0] mode_one;
      logic [7:0] mode_two;
      logic [7:0] clock_select;
      logic       tx_en;
      logic       rx_en;
      dur_ptr_t   ptr;
      logic [7:0] status;
   } dur_chan_st_t;

   dur_chan_st_t st, next_st;

   // Character length code to bit count
   function automatic logic [3:0] dur_bits(input logic [1:0] code);
      dur_bits = {1'b0, BASE_BITS} + {2'h0, code};
   endfunction : dur_bits

   // Next state
   always_comb
   begin
      next_st = st;
      if (mode_acc)
      begin
         if (mode_wr && st.ptr == PTR_ONE) next_st.mode_one = wdata;
         if (mode_wr && st.ptr == PTR_TWO) next_st.mode_two = wdata;
         next_st.ptr = PTR_TWO;
      end
      if (csr_wr) next_st.clock_select = wdata;
      if (cmd_wr)
      begin
         unique case (wdata[3:2])
            CMD_ENABLE:  next_st.tx_en = 1'b1;
            CMD_DISABLE: next_st.tx_en = 1'b0;
            default:     next_st.tx_en = st.tx_en;
         endcase
         unique case (wdata[1:0])
            CMD_ENABLE:  next_st.rx_en = 1'b1;
            CMD_DISABLE: next_st.rx_en = 1'b0;
            default:     next_st.rx_en = st.rx_en;
         endcase
      end
      // Status bits, multi-drop flag replaces parity error
      next_st.status = {stat_in.rx_break, stat_in.framing_err,
                        (st.mode_one[4:3] == PAR_MULTI) ? stat_in.rx_addr_flag
                                                        : stat_in.parity_err,
                        stat_in.overrun_err, stat_in.transmitter_empty,
                        stat_in.transmit_ready, stat_in.fifo_full_flag,
                        stat_in.receive_ready};
   end

   // State register
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst) st <= '{mode_one: RST_ZERO, mode_two: RST_ZERO, clock_select: RST_ZERO,
                          tx_en: 1'b0, rx_en: 1'b0, ptr: PTR_ONE, status: RST_ZERO};
      else if (clk_en) st <= next_st;
   end

   // Decoded fields
   assign cfg.rx_rts_ctl   = st.mode_one[7];
   assign cfg.rx_int_full  = st.mode_one[6];
   assign cfg.block_err    = st.mode_one[5];
   assign cfg.parity_mode  = dur_par_t'(st.mode_one[4:3]);
   assign cfg.parity_odd   = st.mode_one[2];
   assign cfg.data_bits    = dur_bits(st.mode_one[1:0]);
   assign cfg.chan_mode    = dur_cmode_t'(st.mode_two[7:6]);
   assign cfg.tx_rts_ctl   = st.mode_two[5];
   assign cfg.cts_gate     = st.mode_two[4];
   assign cfg.stop_len     = st.mode_two[3:0];
   assign cfg.rx_clk_sel   = st.clock_select[7:4];
   assign cfg.tx_clk_sel   = st.clock_select[3:0];
   assign cfg.tx_enable    = st.tx_en;
   assign cfg.rx_enable    = st.rx_en;
   assign cfg.tx_addr_flag = st.mode_one[2];
   assign status           = st.status;
   assign mode_rdata       = (st.ptr == PTR_ONE) ? st.mode_one : st.mode_two;

endmodule : dur_chan

// >>> core/dur_route.sv
//----------------------------------------------------------------------
// Purpose: Output pin routing between latch bits and internal signals
// Assumes: All sources synchronous to clk_sys
// Notes:   Pins are registered, one cycle behind their sources
//----------------------------------------------------------------------
`timescale 1ns/1ps
module dur_route
   import dur_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       clk_en,
   // Sources
   input  wire logic [7:0] latch,
   input  wire logic [7:0] route_cfg,
   input  wire logic [3:0] stat_src,  // tx ready B, A, rx irq B, A
   input  wire logic [5:0] clk_src,   // ct, txb1, rxb1, txa16, txa1, rxa1
   // Pins
   output logic [7:0]      pins
);

   typedef struct packed {
      logic [7:0] pins;
   } dur_route_st_t;

   dur_route_st_t st, next_st;

   // Pin selection
   always_comb
   begin
      next_st = st;
      for (int i = 4; i < 8; i++)
         next_st.pins[i] = route_cfg[i] ? stat_src[i-4] : latch[i];
      unique case (route_cfg[3:2])
         2'h0: next_st.pins[3] = latch[3];
         2'h1: next_st.pins[3] = clk_src[5];
         2'h2: next_st.pins[3] = clk_src[4];
         2'h3: next_st.pins[3] = clk_src[3];
      endcase
      unique case (route_cfg[1:0])
         2'h0: next_st.pins[2] = latch[2];
         2'h1: next_st.pins[2] = clk_src[2];
         2'h2: next_st.pins[2] = clk_src[1];
         2'h3: next_st.pins[2] = clk_src[0];
      endcase
      next_st.pins[1:0] = latch[1:0];
   end

   // Pin register
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst) st <= '{pins: RST_ZERO};
      else if (clk_en) st <= next_st;
   end

   assign pins = st.pins;

endmodule : dur_route

// >>> core/dur_top.sv
//----------------------------------------------------------------------
// Purpose: Register set of a two-channel asynchronous serial controller
// Assumes: Host port synchronous to clk_sys, one-cycle read strobes
// Notes:   Serial datapath and counter sit outside and use cfg outputs
//----------------------------------------------------------------------
// Operation
// - Each channel has its own mode, command, clock select, status.
// - Mode one bits 1:0 give 5 to 8 data bits.
// - Mode one bits 4:3 pick parity mode, bit 2 odd or even.
// - Mode one bits 7,6,5: rx RTS, rx irq source, error mode.
// - Mode two bits 7:6 pick normal, echo, local or remote loop.
// - Mode two bit 5 tx RTS control, bit 4 CTS gating.
// - Mode two low nibble sets stop length in sixteenths.
// - Command bits 3:2 tx, 1:0 rx: none, enable, disable; 11 ignored.
// - Route bits 7:4 pick latch bit or ready status per pin.
// - Route bits 3:2 pick latch, counter or clock signals; bits 1:0 pick latch or clock signals.
// - Input change register: change flags high nibble, levels low nibble.
// - Interrupt status holds eight flags in fixed order.
// - Interrupt mask enables each status flag at same position.
// - Counter preload is sixteen bits over high and low bytes.
// - Interrupt vector register holds an eight-bit vector.
// - Reset clears status, mask, latch, routing, int status but bits 6, 2 (live break change); vector 0F.
// - Multi-drop transmit sends mode one bit 2 as address flag.
// - Multi-drop receive shows address flag in status bit 5.
//----------------------------------------------------------------------
`timescale 1ns/1ps
module dur_top
   import dur_pkg::*;
(
   // Clock, reset, enable
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       clk_en,
   // Host port
   input  wire logic       bus_cs,
   input  wire logic       bus_rd,
   input  wire logic       bus_wr,
   input  wire logic [3:0] bus_addr,
   input  wire logic [7:0] bus_wdata,
   output logic [7:0]      bus_rdata,
   // Channel datapaths
   input  wire dur_stat_t  stat_a,
   input  wire dur_stat_t  stat_b,
   output dur_cfg_t        cfg_a,
   output dur_cfg_t        cfg_b,
   // Counter/timer
   input  wire logic       ct_ready,
   input  wire logic       ct_out,
   output logic [15:0]     ct_preload,
   output logic [7:0]      auxiliary_control,
   // Clocks offered to output pins
   input  wire logic [5:0] clk_src,
   // General purpose ports
   input  wire logic [3:0] in_pins,
   output logic [7:0]      out_pins,
   // Interrupt
   output logic            int_req,
   output logic [7:0]      interrupt_vector
);

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef struct packed {
      logic [7:0] output_routing_config;
      logic [7:0] auxiliary_control;
      logic [7:0] interrupt_mask;
      logic [7:0] timer_preload_high;
      logic [7:0] timer_preload_low;
      logic [7:0] interrupt_vector;
      logic [7:0] output_latch;
      logic [3:0] in_prev;
      logic [3:0] in_delta;
      logic       ct_flag;
      logic [7:0] rdata;
   } dur_top_st_t;

   dur_top_st_t st, next_st;

   logic       wr_en;
   logic       rd_en;
   logic [7:0] status_a;
   logic [7:0] status_b;
   logic [7:0] mode_rd_a;
   logic [7:0] mode_rd_b;
   logic [7:0] input_change_status;
   logic [7:0] interrupt_status;
   logic       rx_src_a;
   logic       rx_src_b;

   //------------------------------------------------------------
   // Host strobes
   //------------------------------------------------------------
   // Chip select qualifies both strobes
   assign wr_en = bus_cs & bus_wr;
   assign rd_en = bus_cs & bus_rd;

   //------------------------------------------------------------
   // Channels
   //------------------------------------------------------------
   // Two identical copies, one per channel
   dur_chan u_chan_a (
      .clk_sys    (clk_sys),
      .nrst       (nrst),
      .clk_en     (clk_en),
      .mode_acc   ((wr_en | rd_en) && bus_addr == ADR_MODE_A),
      .mode_wr    (wr_en),
      .csr_wr     (wr_en && bus_addr == ADR_STAT_A),
      .cmd_wr     (wr_en && bus_addr == ADR_CMD_A),
      .wdata      (bus_wdata),
      .stat_in    (stat_a),
      .cfg        (cfg_a),
      .status     (status_a),
      .mode_rdata (mode_rd_a)
   );

   dur_chan u_chan_b (
      .clk_sys    (clk_sys),
      .nrst       (nrst),
      .clk_en     (clk_en),
      .mode_acc   ((wr_en | rd_en) && bus_addr == ADR_MODE_B),
      .mode_wr    (wr_en),
      .csr_wr     (wr_en && bus_addr == ADR_STAT_B),
      .cmd_wr     (wr_en && bus_addr == ADR_CMD_B),
      .wdata      (bus_wdata),
      .stat_in    (stat_b),
      .cfg        (cfg_b),
      .status     (status_b),
      .mode_rdata (mode_rd_b)
   );

   //------------------------------------------------------------
   // Interrupt status
   //------------------------------------------------------------
   // Receive source follows the irq-select bit of mode one
   assign rx_src_a = cfg_a.rx_int_full ? status_a[1] : status_a[0];
   assign rx_src_b = cfg_b.rx_int_full ? status_b[1] : status_b[0];

   // Change flags over present levels
   assign input_change_status = {st.in_delta, st.in_prev};

   // Eight flags, bit 7 down
   assign interrupt_status = {|st.in_delta, stat_b.break_change, rx_src_b,
                              status_b[2], st.ct_flag, stat_a.break_change,
                              rx_src_a, status_a[2]};

   // Level output from the masked flags
   assign int_req = |(interrupt_status & st.interrupt_mask);

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      // Counter flag and input sample
      next_st.ct_flag = ct_ready;
      next_st.in_prev = in_pins;
      // Change flags clear on read, a new change wins
      if (rd_en && bus_addr == ADR_AUX) next_st.in_delta = 4'h0;
      next_st.in_delta = next_st.in_delta | (in_pins ^ st.in_prev);
      // Register writes
      if (wr_en)
      begin
         unique case (bus_addr)
            ADR_AUX:    next_st.auxiliary_control = bus_wdata;
            ADR_INT:    next_st.interrupt_mask = bus_wdata;
            ADR_CT_HI:  next_st.timer_preload_high = bus_wdata;
            ADR_CT_LO:  next_st.timer_preload_low = bus_wdata;
            ADR_VECTOR: next_st.interrupt_vector = bus_wdata;
            ADR_ROUTE:  next_st.output_routing_config = bus_wdata;
            ADR_OP_SET: next_st.output_latch = st.output_latch | bus_wdata;
            ADR_OP_CLR: next_st.output_latch = st.output_latch & ~bus_wdata;
            default:    next_st.output_latch = st.output_latch;
         endcase
      end
      // Read data, unmapped reads return zero
      if (rd_en)
      begin
         unique case (bus_addr)
            ADR_MODE_A: next_st.rdata = mode_rd_a;
            ADR_STAT_A: next_st.rdata = status_a;
            ADR_AUX:    next_st.rdata = input_change_status;
            ADR_INT:    next_st.rdata = interrupt_status;
            ADR_MODE_B: next_st.rdata = mode_rd_b;
            ADR_STAT_B: next_st.rdata = status_b;
            ADR_VECTOR: next_st.rdata = st.interrupt_vector;
            default:    next_st.rdata = RST_ZERO;
         endcase
      end
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         st <= '{output_routing_config: RST_ZERO, auxiliary_control: RST_ZERO,
                 interrupt_mask: RST_ZERO, timer_preload_high: RST_ZERO,
                 timer_preload_low: RST_ZERO, interrupt_vector: RST_VECTOR,
                 output_latch: RST_ZERO, in_prev: 4'h0, in_delta: 4'h0,
                 ct_flag: 1'b0, rdata: RST_ZERO};
      end
      else if (clk_en)
      begin
         st <= next_st;
      end
   end

   //------------------------------------------------------------
   // Output pins
   //------------------------------------------------------------
   // Pins registered, one cycle behind
   dur_route u_route (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .clk_en    (clk_en),
      .latch     (st.output_latch),
      .route_cfg (st.output_routing_config),
      .stat_src  ({status_b[2], status_a[2], rx_src_b, rx_src_a}),
      .clk_src   ({ct_out, clk_src[4:0]}),
      .pins      (out_pins)
   );

   // Register views
   assign bus_rdata         = st.rdata;
   assign ct_preload        = {st.timer_preload_high, st.timer_preload_low};
   assign auxiliary_control = st.auxiliary_control;
   assign interrupt_vector  = st.interrupt_vector;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // Host writes and reads land at the taking edge
   chk_vector_write: assert property (
      wr_en && clk_en && bus_addr == ADR_VECTOR |=> interrupt_vector == $past(bus_wdata))
      else $error("vector write lost");

   chk_vector_read: assert property (
      rd_en && clk_en && bus_addr == ADR_VECTOR |=> bus_rdata == $past(interrupt_vector))
      else $error("vector read wrong");

   chk_preload_high: assert property (
      wr_en && clk_en && bus_addr == ADR_CT_HI |=> ct_preload[15:8] == $past(bus_wdata))
      else $error("preload high byte wrong");

   // Command codes, illegal code ignored
   chk_tx_enable: assert property (
      wr_en && clk_en && bus_addr == ADR_CMD_A && bus_wdata[3:2] == CMD_ENABLE
      |=> cfg_a.tx_enable)
      else $error("tx enable command ignored");

   chk_cmd_illegal: assert property (
      wr_en && clk_en && bus_addr == ADR_CMD_B && bus_wdata[1:0] == 2'h3
      |=> cfg_b.rx_enable == $past(cfg_b.rx_enable))
      else $error("illegal rx command acted");

   // Enabled flag raises the request unless the mask is rewritten
   chk_irq_transmit_ready: assert property (
      clk_en && stat_a.transmit_ready && st.interrupt_mask[0] && !(wr_en && bus_addr == ADR_INT)
      |=> int_req)
      else $error("masked tx ready gave no irq");

   // Nothing raised with all masked
   chk_irq_masked: assert property (
      st.interrupt_mask == RST_ZERO |-> !int_req)
      else $error("irq with all masked");

   // Change flag set one cycle after
   chk_delta_set: assert property (
      clk_en && in_pins[0] != st.in_prev[0] |=> input_change_status[4] ##0 interrupt_status[7])
      else $error("input change not flagged");

   // Address flag replaces parity error
   chk_mdrop_flag: assert property (
      clk_en && cfg_a.parity_mode == PAR_MULTI && stat_a.rx_addr_flag |=> status_a[5])
      else $error("address flag not in status");

   // Latch bit on unrouted pin
   chk_route_latch: assert property (
      clk_en && !st.output_routing_config[7] |=> out_pins[7] == $past(st.output_latch[7]))
      else $error("latch not routed to pin");

   // Low preload byte
   chk_preload_low: assert property (
      wr_en && clk_en && bus_addr == ADR_CT_LO |=> ct_preload[7:0] == $past(bus_wdata))
      else $error("preload low byte wrong");

   // Read clears change flags when no new change
   chk_delta_clear: assert property (
      rd_en && clk_en && bus_addr == ADR_AUX && in_pins == st.in_prev
      |=> input_change_status[7:4] == 4'h0)
      else $error("change flags not cleared");

   // Status is a one-cycle copy of the datapath
   chk_status_copy: assert property (
      clk_en |=> status_b[7] == $past(stat_b.rx_break))
      else $error("break status not copied");

   // Counter flag follows its input
   chk_ct_flag: assert property (
      clk_en |=> interrupt_status[3] == $past(ct_ready))
      else $error("counter flag wrong");

   // Counter output routed to pin 3
   chk_route_ct: assert property (
      clk_en && st.output_routing_config[3:2] == 2'h1 |=> out_pins[3] == $past(ct_out))
      else $error("counter output not routed");

   cov_irq:    cover property (int_req ##1 !int_req);
   cov_mdrop:  cover property (cfg_b.parity_mode == PAR_MULTI && status_b[5]);
   cov_ipc_rd: cover property (rd_en && bus_addr == ADR_AUX && |st.in_delta);
   cov_cmd_ill: cover property (wr_en && bus_addr == ADR_CMD_B && bus_wdata[1:0] == 2'h3);
   cov_freeze: cover property (!clk_en && wr_en);

endmodule : dur_top

// >>> tb/dur_host.sv
//----------------------------------------------------------------------
// Purpose: Host processor model on the parallel register port
// Assumes: One-cycle strobes, taken at the edge after they are driven
// Notes:   Released address and data lines show the inverted last value
//----------------------------------------------------------------------
`timescale 1ns/1ps
module dur_host
(
   // Clock
   input  wire logic       clk_sys,
   // Host port
   output logic            bus_cs,
   output logic            bus_rd,
   output logic            bus_wr,
   output logic [3:0]      bus_addr,
   output logic [7:0]      bus_wdata,
   input  wire logic [7:0] bus_rdata
);
   // Idle bus at time zero
   initial
   begin
      {bus_cs, bus_rd, bus_wr, bus_addr, bus_wdata} = '0;
   end

   // One access, held through the taking edge, data taken just after it
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
   begin
      @(posedge clk_sys);
      #1;
      {bus_cs, bus_rd, bus_wr, bus_addr, bus_wdata} = {1'b1, ~w, w, a, d};
      @(posedge clk_sys);
      #1;
      q = bus_rdata;
      {bus_cs, bus_rd, bus_wr} = 3'h0;
      bus_addr = ~a;
      bus_wdata = ~d;
   end
   endtask : acc
endmodule : dur_host

// >>> tb/tb_top.sv
//----------------------------------------------------------------------
// Purpose: Self-checking bench of the dual serial register set
// Assumes: Host model drives the register port, bench drives datapath
// Notes:   Expected values come from the register bit layouts
//----------------------------------------------------------------------
`timescale 1ns/1ps
module tb_top
   import dur_pkg::*;
;
   logic        clk_sys, nrst, clk_en, bus_cs, bus_rd, bus_wr, ct_ready, ct_out, int_req;
   logic [3:0]  bus_addr, in_pins;
   logic [5:0]  clk_src;
   logic [7:0]  bus_wdata, bus_rdata, auxiliary_control, out_pins, interrupt_vector, q;
   logic [7:0]  m1, m2;
   logic [15:0] ct_preload;
   dur_stat_t   stat_a, stat_b;
   dur_cfg_t    cfg_a, cfg_b;
   int          errors, n_checks;
   // Command byte and expected {tx, rx} enables
   logic [9:0]  cmds [8] = '{10'h017, 10'h03F, 10'h003, 10'h028, 10'h012, 10'h00E,
                             10'h020, 10'h005};

   dur_top dur_top_inst (.clk_sys, .nrst, .clk_en, .bus_cs, .bus_rd, .bus_wr, .bus_addr,
      .bus_wdata, .bus_rdata, .stat_a, .stat_b, .cfg_a, .cfg_b, .ct_ready, .ct_out,
      .ct_preload, .auxiliary_control, .clk_src, .in_pins, .out_pins, .int_req,
      .interrupt_vector);
   dur_host dur_host_inst (.clk_sys, .bus_cs, .bus_rd, .bus_wr, .bus_addr, .bus_wdata,
      .bus_rdata);

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
   begin
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   end
   endtask : chk
   task automatic cyc(input int n);
   begin
      repeat (n) @(posedge clk_sys);
      #1;
   end
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
   begin
      dur_host_inst.acc(1'b1, a, d, q);
   end
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
   begin
      dur_host_inst.acc(1'b0, a, 8'h00, q);
      chk(nm, {8'h00, q}, {8'h00, e});
   end
   endtask : rd
   task automatic rst();
   begin
      nrst = 1'b0;
      cyc(2);
      nrst = 1'b1;
   end
   endtask : rst
   task automatic conclude();
   begin
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask : conclude

   // Clock and watchdog
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial
   begin
      #40000;
      errors++;
      conclude();
   end

   // Test sequence
   initial
   begin
      {nrst, ct_ready, ct_out, in_pins, clk_src, stat_a, stat_b} = '0;
      clk_en = 1'b1;
      rst();
      rd(ADR_VECTOR, 8'h0F, "vector");
      rd(ADR_INT, 8'h00, "int status");
      rd(ADR_STAT_A, 8'h00, "status a");
      chk("pins", {8'h00, out_pins}, 16'h0000);
      chk("irq reset", 16'(int_req), 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         rst();
         m1 = {i[0], ~i[0], i[1], i[1:0], i[0], i[1:0]};
         m2 = {i[1:0], i[0], ~i[0], 4'hF - 4'(i)};
         wr(ADR_MODE_A, m1);
         wr(ADR_MODE_A, m2);
         chk("bits", 16'(cfg_a.data_bits), 16'h5 + 16'(i));
         chk("parity", 16'({cfg_a.parity_mode, cfg_a.parity_odd}), 16'({i[1:0], i[0]}));
         chk("rx ctl", 16'({cfg_a.rx_rts_ctl, cfg_a.rx_int_full, cfg_a.block_err}), 16'(m1[7:5]));
         chk("chan mode", 16'(cfg_a.chan_mode), 16'(i[1:0]));
         chk("tx ctl", 16'({cfg_a.tx_rts_ctl, cfg_a.cts_gate}), 16'(m2[5:4]));
         chk("stop", 16'(cfg_a.stop_len), 16'(m2[3:0]));
         chk("chan b", 16'(cfg_b.data_bits), 16'h5);
      end
      chk("addr flag", 16'(cfg_a.tx_addr_flag), 16'(m1[2]));
      $display("test mode done");
      foreach (cmds[k])
      begin
         wr(ADR_CMD_A, cmds[k][9:2]);
         chk("cmd a", 16'({cfg_a.tx_enable, cfg_a.rx_enable}), 16'(cmds[k][1:0]));
      end
      wr(ADR_CMD_B, 8'h07);
      chk("cmd b", 16'({cfg_b.tx_enable, cfg_b.rx_enable, cfg_a.tx_enable}), 16'h4);
      wr(ADR_STAT_A, 8'hA5);
      wr(ADR_STAT_B, 8'h3C);
      chk("clk sel", {cfg_a.rx_clk_sel, cfg_a.tx_clk_sel, cfg_b.rx_clk_sel,
         cfg_b.tx_clk_sel}, 16'hA53C);
      $display("test command done");
      stat_a = '{rx_addr_flag: 1'b1, transmit_ready: 1'b1, default: 1'b0};
      stat_b = '{parity_err: 1'b1, rx_break: 1'b1, receive_ready: 1'b1, default: 1'b0};
      ct_ready = 1'b1;
      cyc(2);
      rd(ADR_STAT_A, 8'h24, "status a");
      rd(ADR_STAT_B, 8'hA1, "status b");
      rd(ADR_INT, 8'h29, "int status");
      wr(ADR_INT, 8'hD6);
      chk("irq off", 16'(int_req), 16'h0);
      wr(ADR_INT, 8'h09);
      chk("irq on", 16'(int_req), 16'h1);
      $display("test status done");
      clk_src = 6'h08;
      wr(ADR_OP_SET, 8'hF3);
      wr(ADR_ROUTE, 8'h5D);
      cyc(2);
      chk("route", 16'(out_pins), 16'hEB);
      wr(ADR_OP_CLR, 8'h81);
      ct_out = 1'b1;
      wr(ADR_ROUTE, 8'h04);
      cyc(2);
      chk("route ct", 16'(out_pins), 16'h7A);
      $display("test routing done");
      wr(ADR_CT_HI, 8'hAB);
      wr(ADR_CT_LO, 8'hCD);
      chk("preload", ct_preload, 16'hABCD);
      wr(ADR_AUX, 8'h30);
      chk("aux", 16'(auxiliary_control), 16'h0030);
      wr(ADR_VECTOR, 8'h5A);
      clk_en = 1'b0;
      wr(ADR_VECTOR, 8'h11);
      clk_en = 1'b1;
      rd(ADR_VECTOR, 8'h5A, "vector");
      chk("vector out", 16'(interrupt_vector), 16'h005A);
      rd(ADR_ROUTE, 8'h00, "route read");
      rd(4'h3, 8'h00, "unmapped");
      $display("test registers done");
      in_pins = 4'h5;
      cyc(2);
      rd(ADR_INT, 8'hA9, "int change");
      rd(ADR_AUX, 8'h55, "in change");
      rd(ADR_AUX, 8'h05, "in cleared");
      $display("test input change done");
      conclude();
   end
endmodule : tb_top
